// ===== hw/acfg_pkg.sv
// Purpose: constants for the serial configuration register bank
// Assumes: 16-bit words, address first, msb first on the serial line
// Notes:   masks give the bits that hold state; other bits read as zero
package acfg_pkg;
    localparam int ACFG_NREG = 12;
    localparam int ACFG_AW   = 8;
    localparam int ACFG_DW   = 8;
    localparam int ACFG_WORD = 16;
    localparam int ACFG_CW   = 4;

    localparam logic [ACFG_CW-1:0] ACFG_ADDR_LAST = 4'h7;
    localparam logic [ACFG_CW-1:0] ACFG_WORD_LAST = 4'hF;
    localparam logic [ACFG_CW-1:0] ACFG_CNT_ZERO  = 4'h0;
    localparam logic [ACFG_CW-1:0] ACFG_CNT_ONE   = 4'h1;

    localparam int ACFG_IDX_CTRL = 0;
    localparam int ACFG_IDX_RATE = 1;
    localparam int ACFG_IDX_PWR  = 2;
    localparam int ACFG_IDX_IFC  = 3;
    localparam int ACFG_IDX_CLKP = 4;
    localparam int ACFG_IDX_FMT  = 5;
    localparam int ACFG_IDX_PATL = 6;
    localparam int ACFG_IDX_PATH = 7;
    localparam int ACFG_IDX_OFFC = 8;
    localparam int ACFG_IDX_GAIN = 9;
    localparam int ACFG_IDX_TPAT = 10;
    localparam int ACFG_IDX_PED  = 11;

    localparam logic [ACFG_NREG-1:0][ACFG_AW-1:0] ACFG_REG_ADDR = {
        8'h63, 8'h62, 8'h55, 8'h53, 8'h52, 8'h51,
        8'h50, 8'h44, 8'h41, 8'h3F, 8'h20, 8'h00};
    localparam logic [ACFG_NREG-1:0][ACFG_DW-1:0] ACFG_REG_MASK = {
        8'h3F, 8'h07, 8'hFF, 8'h40, 8'h3F, 8'hFF,
        8'h06, 8'hFC, 8'hC0, 8'h67, 8'h04, 8'h01};
    localparam logic [ACFG_NREG-1:0][ACFG_DW-1:0] ACFG_REG_DEF = {
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    localparam int ACFG_SOFT_RESET_BIT = 7;
    localparam int ACFG_READBACK_BIT   = 0;
    localparam int ACFG_LOW_SPEED_BIT  = 2;
    localparam int ACFG_PD_BUF_BIT     = 0;
    localparam int ACFG_STANDBY_BIT    = 1;
    localparam int ACFG_PD_GLOBAL_BIT  = 2;
    localparam int ACFG_REF_LSB        = 5;
    localparam int ACFG_REF_W          = 2;
    localparam int ACFG_IFC_LSB        = 6;
    localparam int ACFG_IFC_W          = 2;
    localparam int ACFG_CLKP_LSB       = 2;
    localparam int ACFG_CLKP_W         = 6;
    localparam int ACFG_FMT_LSB        = 1;
    localparam int ACFG_FMT_W          = 2;
    localparam int ACFG_PATH_W         = 6;
    localparam int ACFG_PAT_W          = 14;
    localparam int ACFG_OFFC_BIT       = 6;
    localparam int ACFG_GAIN_LSB       = 4;
    localparam int ACFG_GAIN_W         = 4;
    localparam int ACFG_CTIME_LSB      = 0;
    localparam int ACFG_CTIME_W        = 4;
    localparam int ACFG_TPAT_W         = 3;
    localparam int ACFG_PED_W          = 6;
endpackage : acfg_pkg

// ===== hw/acfg_sync.sv
// Purpose: two-flop level synchroniser, one lane per bit
// Assumes: inputs are levels that stay put for several clocks
// Notes:   first stage is read by the second stage only
`timescale 1ns/1ps
module acfg_sync #(
    parameter int W = 1
) (
    input  wire logic         clock,
    input  wire logic         srst,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge clock) begin
        if (srst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;
endmodule : acfg_sync

// ===== hw/acfg_link.sv
// Purpose: shift-clock side of the serial configuration link
// Assumes: shift clock runs only while select is low
// Notes:   word and toggle stay valid until the next 16th edge
`timescale 1ns/1ps
module acfg_link
    import acfg_pkg::*;
(
    input  wire logic              serial_clock,
    input  wire logic              serial_select_n,
    input  wire logic              serial_in_line,
    input  wire logic              link_clear,
    input  wire logic [ACFG_DW-1:0] rd_data,
    output logic [ACFG_WORD-1:0]   word,
    output logic                   word_toggle,
    output logic [ACFG_AW-1:0]     rd_addr,
    output logic                   read_bit
);
    logic                   frame_clr;
    logic [ACFG_CW-1:0]     cnt_q;
    logic [ACFG_WORD-2:0]   shift_q;
    logic [ACFG_AW-1:0]     addr_q;
    logic [ACFG_WORD-1:0]   word_q;
    logic                   tgl_q;
    logic                   out_q;
    logic                   addr_done;
    logic                   word_done;
    logic [2:0]             out_idx;

    // the clock stands still outside a frame, so the frame's own select
    // or the link clear ends it
    assign frame_clr = serial_select_n | link_clear;
    assign addr_done = (cnt_q == ACFG_ADDR_LAST);
    assign word_done = (cnt_q == ACFG_WORD_LAST);
    assign out_idx   = ~cnt_q[2:0];

    always_ff @(negedge serial_clock or posedge frame_clr) begin
        if (frame_clr) begin
            cnt_q   <= ACFG_CNT_ZERO;
            shift_q <= '0;
            addr_q  <= '0;
        end else begin
            cnt_q   <= cnt_q + ACFG_CNT_ONE;
            shift_q <= {shift_q[ACFG_WORD-3:0], serial_in_line};
            if (addr_done) begin
                addr_q <= {shift_q[ACFG_AW-2:0], serial_in_line};
            end
        end
    end

    // a partial word at frame end never reaches here, so it is dropped
    always_ff @(negedge serial_clock or posedge link_clear) begin
        if (link_clear) begin
            word_q <= '0;
            tgl_q  <= 1'b0;
        end else if (word_done) begin
            word_q <= {shift_q, serial_in_line};
            tgl_q  <= ~tgl_q;
        end
    end

    // rising-edge launch gives the controller half a period of hold
    always_ff @(posedge serial_clock or posedge frame_clr) begin
        if (frame_clr) begin
            out_q <= 1'b0;
        end else begin
            out_q <= cnt_q[3] ? rd_data[out_idx] : 1'b0;
        end
    end

    assign word        = word_q;
    assign word_toggle = tgl_q;
    assign rd_addr     = addr_q;
    assign read_bit    = out_q;
endmodule : acfg_link

// ===== hw/acfg_regbank.sv
// Purpose: serially programmed configuration register bank with readback
// Assumes: reset_pin is active high; overrange_in is on clock's domain
// Notes:   readback reads the bank across domains without a crossing;
//          this holds only because writes other than to the control register are frozen while it is on
`timescale 1ns/1ps
module acfg_regbank
    import acfg_pkg::*;
(
    input  wire logic                   clock,
    input  wire logic                   srst,
    input  wire logic                   serial_clock,
    input  wire logic                   serial_select_n,
    input  wire logic                   serial_in_line,
    input  wire logic                   reset_pin,
    input  wire logic                   overrange_in,
    output logic                        overrange_readback_out,
    output logic                        readback_en,
    output logic                        low_speed_mode,
    output logic [ACFG_REF_W-1:0]       reference_sel,
    output logic                        adc_core_powerdown,
    output logic                        reference_powerdown,
    output logic                        buffer_powerdown,
    output logic [ACFG_IFC_W-1:0]       interface_sel,
    output logic [ACFG_CLKP_W-1:0]      clkout_position,
    output logic [ACFG_FMT_W-1:0]       data_format,
    output logic [ACFG_PAT_W-1:0]       custom_pattern,
    output logic                        offset_corr_en,
    output logic [ACFG_GAIN_W-1:0]      fine_gain,
    output logic [ACFG_CTIME_W-1:0]     corr_time_const,
    output logic [ACFG_TPAT_W-1:0]      test_pattern,
    output logic [ACFG_PED_W-1:0]       offset_pedestal
);
    logic                                 link_clear;
    logic [ACFG_WORD-1:0]                 link_word;
    logic                                 link_tgl;
    logic [ACFG_AW-1:0]                   link_addr;
    logic                                 link_bit;
    logic [ACFG_DW-1:0]                   rb_word;
    logic                                 tgl_s;
    logic                                 hwrst_s;
    logic                                 tgl_seen_q;
    logic                                 word_evt;
    logic [ACFG_AW-1:0]                   wr_addr;
    logic [ACFG_DW-1:0]                   wr_data;
    logic                                 rb_on;
    logic                                 ctrl_hit;
    logic                                 wr_allowed;
    logic                                 soft_rst;
    logic                                 bank_clr;
    logic [ACFG_NREG-1:0]                 addr_hit;
    logic [ACFG_NREG-1:0]                 rd_hit;
    logic [ACFG_NREG-1:0]                 wr_hit;
    logic [ACFG_NREG:0][ACFG_DW-1:0]      rd_chain;
    logic [ACFG_NREG-1:0][ACFG_DW-1:0]    cfg_q;
    logic                                 ovr_q;
    logic                                 core_pd_q;
    logic                                 ref_pd_q;
    logic                                 buf_pd_q;

    // the shift clock may be stopped during reset, so only an
    // asynchronous clear reaches the link side
    assign link_clear = srst | reset_pin;

    acfg_link u_link (
        .serial_clock    (serial_clock),
        .serial_select_n (serial_select_n),
        .serial_in_line  (serial_in_line),
        .link_clear      (link_clear),
        .rd_data         (rb_word),
        .word            (link_word),
        .word_toggle     (link_tgl),
        .rd_addr         (link_addr),
        .read_bit        (link_bit)
    );

    acfg_sync #(
        .W (2)
    ) u_sync (
        .clock    (clock),
        .srst     (srst),
        .async_in ({link_tgl, reset_pin}),
        .sync_out ({tgl_s, hwrst_s})
    );

    always_ff @(posedge clock) begin
        if (srst) begin
            tgl_seen_q <= 1'b0;
        end else begin
            tgl_seen_q <= tgl_s;
        end
    end

    // link word is stable for 16 shift edges, far longer than the sync
    assign word_evt = tgl_s ^ tgl_seen_q;
    assign wr_addr  = link_word[ACFG_WORD-1 -: ACFG_AW];
    assign wr_data  = link_word[ACFG_DW-1:0];
    assign rb_on    = cfg_q[ACFG_IDX_CTRL][ACFG_READBACK_BIT];
    assign ctrl_hit = addr_hit[ACFG_IDX_CTRL];

    // words taken while the reset pin is held are dropped
    assign wr_allowed = word_evt & ~hwrst_s & (~rb_on | ctrl_hit);
    assign soft_rst   = wr_allowed & ctrl_hit & ~rb_on
                        & wr_data[ACFG_SOFT_RESET_BIT];
    assign bank_clr   = srst | hwrst_s | soft_rst;

    genvar gi;
    assign rd_chain[0] = '0;
    generate
        for (gi = 0; gi < ACFG_NREG; gi++) begin : g_dec
            assign addr_hit[gi] = (wr_addr == ACFG_REG_ADDR[gi]);
            assign wr_hit[gi]   = wr_allowed & addr_hit[gi];
            assign rd_hit[gi]   = (link_addr == ACFG_REG_ADDR[gi]);
            assign rd_chain[gi+1] = rd_chain[gi]
                                    | (rd_hit[gi] ? cfg_q[gi] : '0);
        end
    endgenerate
    // unmapped addresses read back as zero
    assign rb_word = rd_chain[ACFG_NREG];

    // whole byte is loaded at once; the self-clearing reset bit is
    // masked off, so it always reads zero
    always_ff @(posedge clock) begin
        for (int i = 0; i < ACFG_NREG; i++) begin
            if (bank_clr) begin
                cfg_q[i] <= ACFG_REG_DEF[i];
            end else if (wr_hit[i]) begin
                cfg_q[i] <= wr_data & ACFG_REG_MASK[i];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            ovr_q     <= 1'b0;
            core_pd_q <= 1'b0;
            ref_pd_q  <= 1'b0;
            buf_pd_q  <= 1'b0;
        end else begin
            ovr_q     <= overrange_in;
            core_pd_q <= cfg_q[ACFG_IDX_PWR][ACFG_STANDBY_BIT]
                         | cfg_q[ACFG_IDX_PWR][ACFG_PD_GLOBAL_BIT];
            ref_pd_q  <= cfg_q[ACFG_IDX_PWR][ACFG_PD_GLOBAL_BIT];
            buf_pd_q  <= cfg_q[ACFG_IDX_PWR][ACFG_PD_BUF_BIT]
                         | cfg_q[ACFG_IDX_PWR][ACFG_PD_GLOBAL_BIT];
        end
    end

    // both legs come from flops; only the select is a register bit
    assign overrange_readback_out = rb_on ? link_bit : ovr_q;

    assign readback_en         = rb_on;
    assign low_speed_mode      =
        cfg_q[ACFG_IDX_RATE][ACFG_LOW_SPEED_BIT];
    assign reference_sel       =
        cfg_q[ACFG_IDX_PWR][ACFG_REF_LSB +: ACFG_REF_W];
    assign adc_core_powerdown  = core_pd_q;
    assign reference_powerdown = ref_pd_q;
    assign buffer_powerdown    = buf_pd_q;
    assign interface_sel       =
        cfg_q[ACFG_IDX_IFC][ACFG_IFC_LSB +: ACFG_IFC_W];
    assign clkout_position     =
        cfg_q[ACFG_IDX_CLKP][ACFG_CLKP_LSB +: ACFG_CLKP_W];
    assign data_format         =
        cfg_q[ACFG_IDX_FMT][ACFG_FMT_LSB +: ACFG_FMT_W];
    assign custom_pattern      = {cfg_q[ACFG_IDX_PATH][ACFG_PATH_W-1:0],
                                  cfg_q[ACFG_IDX_PATL]};
    assign offset_corr_en      = cfg_q[ACFG_IDX_OFFC][ACFG_OFFC_BIT];
    assign fine_gain           =
        cfg_q[ACFG_IDX_GAIN][ACFG_GAIN_LSB +: ACFG_GAIN_W];
    assign corr_time_const     =
        cfg_q[ACFG_IDX_GAIN][ACFG_CTIME_LSB +: ACFG_CTIME_W];
    assign test_pattern        = cfg_q[ACFG_IDX_TPAT][ACFG_TPAT_W-1:0];
    assign offset_pedestal     = cfg_q[ACFG_IDX_PED][ACFG_PED_W-1:0];
endmodule : acfg_regbank

// ===== sim/acfg_regbank_props.sv
// Purpose: port-level timing checks for the register bank
// Assumes: select stays high for some clocks between frames
// Notes:   link-edge timing is judged by the bench instead
`timescale 1ns/1ps
module acfg_regbank_props
    import acfg_pkg::*;
(
    input wire logic                    clock,
    input wire logic                    srst,
    input wire logic                    serial_select_n,
    input wire logic                    reset_pin,
    input wire logic                    overrange_in,
    input wire logic                    overrange_readback_out,
    input wire logic                    readback_en,
    input wire logic                    low_speed_mode,
    input wire logic                    adc_core_powerdown,
    input wire logic                    reference_powerdown,
    input wire logic                    buffer_powerdown,
    input wire logic [ACFG_PAT_W-1:0]   custom_pattern,
    input wire logic [ACFG_GAIN_W-1:0]  fine_gain,
    input wire logic [ACFG_CTIME_W-1:0] corr_time_const
);
    logic [3:0]  pin_q;
    logic [3:0]  idle_q;
    wire  [26:0] cfg = {readback_en, low_speed_mode, adc_core_powerdown,
        reference_powerdown, buffer_powerdown, custom_pattern, fine_gain,
        corr_time_const};
    // counters keep quiet checks clear of words still crossing domains
    always_ff @(posedge clock) begin
        if (srst || reset_pin) pin_q <= 4'h0;
        else if (pin_q != 4'hF) pin_q <= pin_q + 4'h1;
        if (srst || reset_pin || !serial_select_n) idle_q <= 4'h0;
        else if (idle_q != 4'hF) idle_q <= idle_q + 4'h1;
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    sequence s_pin_held; reset_pin [*8]; endsequence
    sequence s_quiet; idle_q >= 4'h8; endsequence
    property p_pin_clear; s_pin_held |-> cfg == '0; endproperty
    property p_first; $fell(srst) |-> (cfg == '0) [*2]; endproperty
    property p_pass; !readback_en && !$past(srst) && pin_q >= 4'h4 |->
        overrange_readback_out == $past(overrange_in); endproperty
    property p_rb_idle; readback_en && serial_select_n &&
        $past(serial_select_n) |-> !overrange_readback_out; endproperty
    property p_pd_global; reference_powerdown |->
        adc_core_powerdown && buffer_powerdown; endproperty
    property p_frozen; readback_en && $past(readback_en) |-> $stable(cfg);
    endproperty
    property p_quiet; s_quiet |-> $stable(cfg); endproperty
    property p_exit; $fell(readback_en) && pin_q >= 4'h8 |->
        $stable(cfg[25:0]); endproperty
    a_pin_clear: assert property (p_pin_clear)
        else $error("bank not cleared by reset pin");
    a_first: assert property (p_first)
        else $error("outputs not zero after reset");
    a_pass: assert property (p_pass)
        else $error("overrange pass-through wrong");
    a_rb_idle: assert property (p_rb_idle)
        else $error("readback pin not idle");
    a_pd_global: assert property (p_pd_global)
        else $error("global powerdown incomplete");
    a_frozen: assert property (p_frozen)
        else $error("register changed during readback");
    a_quiet: assert property (p_quiet)
        else $error("register changed with link idle");
    a_exit: assert property (p_exit)
        else $error("readback exit disturbed registers");
endmodule : acfg_regbank_props
bind acfg_regbank acfg_regbank_props u_props (.*);

// ===== sim/acfg_ctl_model.sv
// Purpose: controller model driving the serial configuration link
// Assumes: shift clock idles high and runs only inside frames
// Notes:   hp is the half period; raise it for a slow controller
`timescale 1ns/1ps
module acfg_ctl_model (
    output logic     serial_clock,
    output logic     serial_select_n,
    output logic     serial_in_line,
    input wire logic overrange_readback_out
);
    realtime hp = 62.5;
    initial begin
        serial_clock = 1'b1;
        serial_select_n = 1'b1;
        serial_in_line = 1'b0;
    end
    // nb bits of v, msb first; rd keeps the tail of the last word
    task automatic frame(input logic [39:0] v, input int nb,
                         output logic [7:0] rd);
        serial_select_n = 1'b0;
        // odd offset keeps shift edges off the system clock's edges
        #(hp + 7.0);
        for (int i = 0; i < nb; i++) begin
            serial_in_line = v[39-i];
            #(hp) serial_clock = 1'b0;
            if (i % 16 > 7) rd[15 - i % 16] = overrange_readback_out;
            #(hp) serial_clock = 1'b1;
        end
        #(hp) serial_select_n = 1'b1;
        // a released line must not keep showing the last bit
        serial_in_line = ~serial_in_line;
    endtask : frame
endmodule : acfg_ctl_model

// ===== sim/tb.sv
// Purpose: self-checking bench for the serial configuration bank
// Assumes: one controller model drives the link
// Notes:   expected values come from a register model in the bench
`timescale 1ns/1ps
module tb;
    import acfg_pkg::*;
    logic clock, srst, reset_pin, overrange_in, serial_clock;
    logic serial_select_n, serial_in_line, overrange_readback_out;
    logic readback_en, low_speed_mode, adc_core_powerdown;
    logic reference_powerdown, buffer_powerdown, offset_corr_en;
    logic [ACFG_REF_W-1:0]   reference_sel;
    logic [ACFG_IFC_W-1:0]   interface_sel;
    logic [ACFG_CLKP_W-1:0]  clkout_position;
    logic [ACFG_FMT_W-1:0]   data_format;
    logic [ACFG_PAT_W-1:0]   custom_pattern;
    logic [ACFG_GAIN_W-1:0]  fine_gain;
    logic [ACFG_CTIME_W-1:0] corr_time_const;
    logic [ACFG_TPAT_W-1:0]  test_pattern;
    logic [ACFG_PED_W-1:0]   offset_pedestal;
    logic [7:0]              mdl [ACFG_NREG];
    int                      failures;
    int                      tests_run;

    acfg_regbank DUT (.*);
    acfg_ctl_model ctl (.*);

    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [63:0] e, g);
        tests_run++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic cmp_all();
        logic [7:0] p;
        p = mdl[2];
        chk("outputs", 64'({mdl[0][0], mdl[1][2], p[6:5],
            p[1] | p[2], p[2], p[0] | p[2], mdl[3][7:6], mdl[4][7:2],
            mdl[5][2:1], mdl[7][5:0], mdl[6], mdl[8][6], mdl[9],
            mdl[10][2:0], mdl[11][5:0]}), 64'({readback_en, low_speed_mode,
            reference_sel, adc_core_powerdown, reference_powerdown,
            buffer_powerdown, interface_sel, clkout_position, data_format,
            custom_pattern, offset_corr_en, fine_gain, corr_time_const,
            test_pattern, offset_pedestal}));
    endtask : cmp_all
    task automatic settle();
        repeat (8) @(posedge clock);
        @(negedge clock);
        cmp_all();
    endtask : settle
    task automatic mdl_wr(input logic [7:0] a, d);
        logic rb;
        rb = mdl[0][0];
        for (int i = 0; i < ACFG_NREG; i++)
            if (a == ACFG_REG_ADDR[i]) begin
                if (i == 0 && d[7] && !rb) mdl = '{default: 8'h00};
                else if (i == 0) mdl[0] = d & ACFG_REG_MASK[0];
                else if (!rb) mdl[i] = d & ACFG_REG_MASK[i];
            end
    endtask : mdl_wr
    task automatic xw(input logic [7:0] a, d);
        logic [7:0] r;
        ctl.frame({a, d, 24'h00_0000}, 16, r);
        for (int i = 0; i < ACFG_NREG; i++)
            if (mdl[0][0] && a == ACFG_REG_ADDR[i])
                chk("readback", 64'(mdl[i]), 64'(r));
        mdl_wr(a, d);
        settle();
    endtask : xw

    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    always @(negedge clock) overrange_in <= 1'($urandom);
    initial begin
        repeat (100000) @(posedge clock);
        failures++;
        end_sim();
    end
    initial begin
        logic [7:0] r;
        void'($urandom(32'he25f_9f61));
        srst = 1'b1;
        reset_pin = 1'b0;
        mdl = '{default: 8'h00};
        repeat (8) @(posedge clock);
        @(negedge clock) srst = 1'b0;
        settle();
        repeat (2) for (int i = 1; i < ACFG_NREG; i++)
            xw(ACFG_REG_ADDR[i], 8'($urandom));
        xw(8'h10, 8'hFF);
        xw(8'h00, 8'h01);
        for (int i = 0; i < ACFG_NREG; i++)
            xw(ACFG_REG_ADDR[i], 8'($urandom) | 8'h01);
        xw(8'h00, 8'h80);
        xw(8'h20, 8'h04);
        xw(8'h00, 8'h80);
        ctl.frame({8'h55, 8'hA7, 8'h63, 8'h2A, 8'h52}, 37, r);
        mdl_wr(8'h55, 8'hA7);
        mdl_wr(8'h63, 8'h2A);
        settle();
        ctl.frame({8'h20, 8'h04, 24'h00_0000}, 15, r);
        settle();
        xw(8'h3F, 8'h04);
        @(negedge clock) reset_pin = 1'b1;
        repeat (9) @(negedge clock);
        reset_pin = 1'b0;
        mdl = '{default: 8'h00};
        repeat (3) @(negedge clock);
        settle();
        xw(8'h3F, 8'h02);
        xw(8'h3F, 8'h01);
        end_sim();
    end
endmodule : tb
